/* File: cmd_decoder_pkg.sv */
// Purpose: Shared constants for the display command decoder.
// Assumes: Byte-wide command stream and 32-bit APB register access.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
package cmd_decoder_pkg;

  localparam logic [7:0] OP_LOW_COL_BASE   = 8'h00;
  localparam logic [7:0] OP_HIGH_COL_BASE  = 8'h10;
  localparam logic [7:0] OP_ADDR_MODE      = 8'h20;
  localparam logic [7:0] OP_COL_WINDOW     = 8'h21;
  localparam logic [7:0] OP_PAGE_WINDOW    = 8'h22;
  localparam logic [7:0] OP_SCROLL_RIGHT   = 8'h26;
  localparam logic [7:0] OP_SCROLL_LEFT    = 8'h27;
  localparam logic [7:0] OP_CONTRAST       = 8'h81;
  localparam logic [7:0] OP_SEG_REMAP0     = 8'ha0;
  localparam logic [7:0] OP_SEG_REMAP1     = 8'ha1;
  localparam logic [7:0] OP_FOLLOW_RAM     = 8'ha4;
  localparam logic [7:0] OP_ALL_ON         = 8'ha5;
  localparam logic [7:0] OP_NORMAL         = 8'ha6;
  localparam logic [7:0] OP_INVERSE        = 8'ha7;
  localparam logic [7:0] OP_MUX_RATIO      = 8'ha8;
  localparam logic [7:0] OP_IREF_SEL       = 8'had;
  localparam logic [7:0] OP_DISPLAY_OFF    = 8'hae;
  localparam logic [7:0] OP_DISPLAY_ON     = 8'haf;
  localparam logic [7:0] OP_SCAN_UP        = 8'hc0;
  localparam logic [7:0] OP_SCAN_DOWN      = 8'hc8;
  localparam logic [7:0] OP_OFFSET         = 8'hd3;
  localparam logic [7:0] OP_CLOCK_DIV      = 8'hd5;
  localparam logic [7:0] OP_PRECHARGE      = 8'hd9;
  localparam logic [7:0] OP_COM_PINS       = 8'hda;
  localparam logic [7:0] OP_NOP            = 8'he3;

  localparam logic [1:0] MODE_HORIZONTAL   = 2'h0;
  localparam logic [1:0] MODE_VERTICAL     = 2'h1;
  localparam logic [1:0] MODE_PAGE         = 2'h2;
  localparam logic [1:0] MODE_INVALID      = 2'h3;

  localparam logic [1:0] RST_ADDR_MODE     = 2'h2;
  localparam logic [6:0] RST_COL_START     = 7'h00;
  localparam logic [6:0] RST_COL_END       = 7'h7f;
  localparam logic [2:0] RST_PAGE_START    = 3'h0;
  localparam logic [2:0] RST_PAGE_END      = 3'h7;
  localparam logic [7:0] RST_CONTRAST      = 8'h7f;
  localparam logic [5:0] RST_MUX           = 6'h3f;
  localparam logic [5:0] MUX_MIN_VALID     = 6'h0f;
  localparam logic [3:0] RST_CLK_DIV       = 4'h0;
  localparam logic [3:0] RST_OSC_FREQ      = 4'h8;
  localparam logic [3:0] RST_PHASE         = 4'h2;
  localparam logic       RST_COM_ALT       = 1'b1;

  // APB map; all registers are of own choosing.
  localparam logic [7:0] ADDR_CMD          = 8'h00;
  localparam logic [7:0] ADDR_DATA_ACCESS  = 8'h04;
  localparam logic [7:0] ADDR_ADDRESSING   = 8'h08;
  localparam logic [7:0] ADDR_DISPLAY      = 8'h0c;
  localparam logic [7:0] ADDR_TIMING       = 8'h10;
  localparam logic [7:0] ADDR_SCROLL       = 8'h14;
  localparam logic [7:0] ADDR_POINTER      = 8'h18;
  localparam logic [7:0] ADDR_STATUS       = 8'h1c;

  localparam int unsigned PARAM_MAX        = 6;

endpackage : cmd_decoder_pkg

/* File: scroll_interval_lut.sv */
// Purpose: Maps the scroll step code to a step interval in frames.
// Assumes: Code is a stable register value.
// Notes:   Output is registered.
`timescale 1ns/1ps
`default_nettype none
module scroll_interval_lut (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [2:0] code_i,
  output logic      [8:0] frames_o
);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frames_o <= 9'h005;
    end else begin
      case (code_i)
        3'h0:    frames_o <= 9'h005;
        3'h1:    frames_o <= 9'h040;
        3'h2:    frames_o <= 9'h080;
        3'h3:    frames_o <= 9'h100;
        3'h4:    frames_o <= 9'h003;
        3'h5:    frames_o <= 9'h004;
        3'h6:    frames_o <= 9'h019;
        default: frames_o <= 9'h002;
      endcase
    end
  end

endmodule : scroll_interval_lut
`default_nettype wire

/* File: column_pointer.sv */
// Purpose: Column and page access pointer of the frame buffer.
// Assumes: One access pulse per data byte.
// Notes:   Horizontal and vertical walking wrap at the window ends; setting a window does not move the pointer into it.
`timescale 1ns/1ps
`default_nettype none
module column_pointer (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [1:0] mode_i,
  input  wire logic [6:0] col_start_i,
  input  wire logic [6:0] col_end_i,
  input  wire logic [2:0] page_start_i,
  input  wire logic [2:0] page_end_i,
  input  wire logic       load_i,
  input  wire logic [6:0] load_col_i,
  input  wire logic [2:0] load_page_i,
  input  wire logic       access_i,
  output logic      [6:0] col_o,
  output logic      [2:0] page_o
);
  import cmd_decoder_pkg::*;

  logic col_wrap;
  logic page_wrap;
  assign col_wrap  = (col_o == col_end_i);
  assign page_wrap = (page_o == page_end_i);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      col_o  <= 7'h00;
      page_o <= 3'h0;
    end else if (load_i) begin
      col_o  <= load_col_i;
      page_o <= load_page_i;
    end else if (access_i) begin
      case (mode_i)
        MODE_PAGE: begin
          // Page stays put on wrap; the host must repoint itself.
          col_o <= col_wrap ? col_start_i : col_o + 7'h01;
        end
        MODE_HORIZONTAL: begin
          col_o <= col_wrap ? col_start_i : col_o + 7'h01;
          if (col_wrap) begin
            page_o <= page_wrap ? page_start_i : page_o + 3'h1;
          end
        end
        MODE_VERTICAL: begin
          page_o <= page_wrap ? page_start_i : page_o + 3'h1;
          if (page_wrap) begin
            col_o <= col_wrap ? col_start_i : col_o + 7'h01;
          end
        end
        default: col_o <= col_o;
      endcase
    end
  end

endmodule : column_pointer
`default_nettype wire

/* File: oled_command_decoder.sv */
// Purpose: Command byte decoder and configuration store of a dot-matrix
//          display driver, reached over APB.
// Assumes: Host writes one command or parameter byte per APB write.
// Notes:   Configuration also appears on dedicated output ports.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Opcodes 00h-0Fh set low nibble, 10h-1Fh high nibble of page column start.
// - Opcode 20h plus one byte selects addressing mode; reset is page mode.
// - Opcode 21h plus two bytes sets column window, reset 0 and 127.
// - Opcode 22h plus two bytes sets page window, reset 0 and 7.
// - Opcodes 40h-7Fh set display start line from low six bits.
// - Opcode 81h plus one byte sets contrast; reset 7Fh.
// - A0h maps column 0, A1h column 127, to first segment output.
// - A4h follows frame buffer; A5h lights every pixel.
// - A6h normal display, A7h inverse display.
// - A8h plus byte sets mux ratio N+1; N below 15 invalid.
// - ADh plus byte, bit 4 selects internal reference current.
// - AEh display off (reset), AFh display on.
// - Opcodes B0h-B7h set page start for page addressing mode.
// - C0h scans rows upward, C8h downward.
// - D3h plus byte sets vertical shift 0 to 63.
// - D5h plus byte sets clock divide and oscillator frequency.
// - D9h plus byte sets phase 1 and 2 lengths; zero invalid.
// - DAh plus byte sets common pin layout and left/right swap.
// - E3h does nothing.
// - 26h/27h plus six bytes set up continuous horizontal scroll.
// - Scroll step code maps to 5,64,128,256,3,4,25,2 frames.
// - Page mode column pointer wraps to start, page unchanged.
module oled_command_decoder (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             display_on_o,
  output logic             all_on_o,
  output logic             inverse_o,
  output logic             seg_remap_o,
  output logic             scan_down_o,
  output logic      [7:0]  contrast_o,
  output logic      [5:0]  mux_ratio_o,
  output logic      [5:0]  start_line_o,
  output logic      [5:0]  offset_o,
  output logic             iref_internal_o,
  output logic      [6:0]  col_o,
  output logic      [2:0]  ram_page_index_o,
  output logic      [8:0]  scroll_frames_o
);
  import cmd_decoder_pkg::*;

  typedef enum logic [1:0] {
    ST_OPCODE = 2'b00,
    ST_PARAM  = 2'b01
  } dec_state_e;

  dec_state_e state_ff;
  logic [7:0] op_ff;
  logic [2:0] idx_ff;
  logic [1:0] mode_ff;
  logic [6:0] col_start_ff;
  logic [6:0] col_end_ff;
  logic [2:0] page_start_ff;
  logic [2:0] page_end_ff;
  logic [3:0] pcol_low_ff;
  logic [3:0] pcol_high_ff;
  logic [2:0] ppage_ff;
  logic [5:0] start_line_ff;
  logic [7:0] contrast_ff;
  logic       seg_remap_ff;
  logic       all_on_ff;
  logic       inverse_ff;
  logic [5:0] mux_ff;
  logic       iref_int_ff;
  logic       display_on_ff;
  logic       scan_down_ff;
  logic [5:0] offset_ff;
  logic [3:0] clk_div_ff;
  logic [3:0] osc_freq_ff;
  logic [3:0] phase1_ff;
  logic [3:0] phase2_ff;
  logic       com_alt_ff;
  logic       com_swap_ff;
  logic       scroll_left_ff;
  logic [2:0] scroll_start_ff;
  logic [2:0] scroll_code_ff;
  logic [2:0] scroll_end_ff;
  logic       bad_param_ff;
  logic       ptr_load_ff;

  logic       wr_acc;
  logic       byte_wr;
  logic       data_acc;
  logic [7:0] wbyte;
  logic       in_param;

  // Number of parameter bytes each opcode takes.
  function automatic logic [2:0] param_count(input logic [7:0] op);
    case (op)
      OP_ADDR_MODE, OP_CONTRAST, OP_MUX_RATIO, OP_IREF_SEL,
      OP_OFFSET, OP_CLOCK_DIV, OP_PRECHARGE, OP_COM_PINS:
        param_count = 3'd1;
      OP_COL_WINDOW, OP_PAGE_WINDOW:
        param_count = 3'd2;
      OP_SCROLL_RIGHT, OP_SCROLL_LEFT:
        param_count = 3'd6;
      default:
        param_count = 3'd0;
    endcase
  endfunction : param_count

  // APB is zero-wait: every access completes in its access phase.
  assign pready   = 1'b1;
  assign wr_acc   = psel && penable && pwrite;
  assign byte_wr  = wr_acc && (paddr == ADDR_CMD) && pstrb[0];
  assign data_acc = wr_acc && (paddr == ADDR_DATA_ACCESS);
  assign wbyte    = pwdata[7:0];
  assign in_param = (state_ff == ST_PARAM);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= 1'b0;
    end
  end

  // Sequencer: opcode, then its parameters in order.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_OPCODE;
      op_ff    <= 8'h00;
      idx_ff   <= 3'h0;
    end else if (byte_wr) begin
      case (state_ff)
        ST_OPCODE: begin
          op_ff  <= wbyte;
          idx_ff <= 3'h0;
          if (param_count(wbyte) != 3'd0) begin
            state_ff <= ST_PARAM;
          end
        end
        ST_PARAM: begin
          idx_ff <= idx_ff + 3'h1;
          if (idx_ff + 3'h1 == param_count(op_ff)) begin
            state_ff <= ST_OPCODE;
          end
        end
        default: begin
          state_ff <= ST_OPCODE;
        end
      endcase
    end
  end

  // Single-byte opcodes.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pcol_low_ff   <= 4'h0;
      pcol_high_ff  <= 4'h0;
      ppage_ff      <= 3'h0;
      start_line_ff <= 6'h00;
      seg_remap_ff  <= 1'b0;
      all_on_ff     <= 1'b0;
      inverse_ff    <= 1'b0;
      display_on_ff <= 1'b0;
      scan_down_ff  <= 1'b0;
      ptr_load_ff   <= 1'b0;
    end else begin
      ptr_load_ff <= 1'b0;
      if (byte_wr && !in_param) begin
        if (wbyte[7:4] == OP_LOW_COL_BASE[7:4]) begin
          pcol_low_ff <= wbyte[3:0];
          ptr_load_ff <= (mode_ff == MODE_PAGE);
        end
        if (wbyte[7:4] == OP_HIGH_COL_BASE[7:4]) begin
          pcol_high_ff <= wbyte[3:0];
          ptr_load_ff  <= (mode_ff == MODE_PAGE);
        end
        if (wbyte[7:6] == 2'b01) begin
          start_line_ff <= wbyte[5:0];
        end
        if (wbyte[7:3] == 5'b10110) begin
          ppage_ff    <= wbyte[2:0];
          ptr_load_ff <= (mode_ff == MODE_PAGE);
        end
        case (wbyte)
          OP_SEG_REMAP0:  seg_remap_ff  <= 1'b0;
          OP_SEG_REMAP1:  seg_remap_ff  <= 1'b1;
          OP_FOLLOW_RAM:  all_on_ff     <= 1'b0;
          OP_ALL_ON:      all_on_ff     <= 1'b1;
          OP_NORMAL:      inverse_ff    <= 1'b0;
          OP_INVERSE:     inverse_ff    <= 1'b1;
          OP_DISPLAY_OFF: display_on_ff <= 1'b0;
          OP_DISPLAY_ON:  display_on_ff <= 1'b1;
          OP_SCAN_UP:     scan_down_ff  <= 1'b0;
          OP_SCAN_DOWN:   scan_down_ff  <= 1'b1;
          OP_NOP:         scan_down_ff  <= scan_down_ff;
          default:        scan_down_ff  <= scan_down_ff;
        endcase
      end
    end
  end

  // Parameter bytes of multi-byte commands.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_ff         <= RST_ADDR_MODE;
      col_start_ff    <= RST_COL_START;
      col_end_ff      <= RST_COL_END;
      page_start_ff   <= RST_PAGE_START;
      page_end_ff     <= RST_PAGE_END;
      contrast_ff     <= RST_CONTRAST;
      mux_ff          <= RST_MUX;
      iref_int_ff     <= 1'b0;
      offset_ff       <= 6'h00;
      clk_div_ff      <= RST_CLK_DIV;
      osc_freq_ff     <= RST_OSC_FREQ;
      phase1_ff       <= RST_PHASE;
      phase2_ff       <= RST_PHASE;
      com_alt_ff      <= RST_COM_ALT;
      com_swap_ff     <= 1'b0;
      scroll_left_ff  <= 1'b0;
      scroll_start_ff <= 3'h0;
      scroll_code_ff  <= 3'h0;
      scroll_end_ff   <= 3'h0;
      bad_param_ff    <= 1'b0;
    end else if (byte_wr && in_param) begin
      case (op_ff)
        OP_ADDR_MODE: begin
          // An invalid mode is refused so the pointer never stalls.
          if (wbyte[1:0] != MODE_INVALID) begin
            mode_ff <= wbyte[1:0];
          end
          bad_param_ff <= (wbyte[1:0] == MODE_INVALID);
        end
        OP_COL_WINDOW: begin
          if (idx_ff == 3'h0) begin
            col_start_ff <= wbyte[6:0];
          end else begin
            col_end_ff <= wbyte[6:0];
          end
        end
        OP_PAGE_WINDOW: begin
          if (idx_ff == 3'h0) begin
            page_start_ff <= wbyte[2:0];
          end else begin
            page_end_ff <= wbyte[2:0];
          end
        end
        OP_CONTRAST: contrast_ff <= wbyte;
        OP_MUX_RATIO: begin
          if (wbyte[5:0] >= MUX_MIN_VALID) begin
            mux_ff <= wbyte[5:0];
          end
          bad_param_ff <= (wbyte[5:0] < MUX_MIN_VALID);
        end
        OP_IREF_SEL: iref_int_ff <= wbyte[4];
        OP_OFFSET:   offset_ff   <= wbyte[5:0];
        OP_CLOCK_DIV: begin
          clk_div_ff  <= wbyte[3:0];
          osc_freq_ff <= wbyte[7:4];
        end
        OP_PRECHARGE: begin
          if (wbyte[3:0] != 4'h0) begin
            phase1_ff <= wbyte[3:0];
          end
          if (wbyte[7:4] != 4'h0) begin
            phase2_ff <= wbyte[7:4];
          end
          bad_param_ff <= (wbyte[3:0] == 4'h0) || (wbyte[7:4] == 4'h0);
        end
        OP_COM_PINS: begin
          com_alt_ff  <= wbyte[4];
          com_swap_ff <= wbyte[5];
        end
        OP_SCROLL_RIGHT, OP_SCROLL_LEFT: begin
          scroll_left_ff <= op_ff[0];
          case (idx_ff)
            3'h1:    scroll_start_ff <= wbyte[2:0];
            3'h2:    scroll_code_ff  <= wbyte[2:0];
            3'h3:    scroll_end_ff   <= wbyte[2:0];
            default: scroll_left_ff  <= op_ff[0];
          endcase
        end
        default: bad_param_ff <= bad_param_ff;
      endcase
    end
  end

  column_pointer u_column_pointer (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .mode_i       (mode_ff),
    .col_start_i  (col_start_ff),
    .col_end_i    (col_end_ff),
    .page_start_i (page_start_ff),
    .page_end_i   (page_end_ff),
    .load_i       (ptr_load_ff),
    .load_col_i   ({pcol_high_ff[2:0], pcol_low_ff}),
    .load_page_i  (ppage_ff),
    .access_i     (data_acc),
    .col_o        (col_o),
    .page_o       (ram_page_index_o)
  );

  scroll_interval_lut u_scroll_interval_lut (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .code_i   (scroll_code_ff),
    .frames_o (scroll_frames_o)
  );

  // Register reads; unmapped offsets read as zero.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_ADDRESSING: prdata <= {2'h0, page_end_ff, page_start_ff,
                                    1'b0, col_end_ff, 1'b0, col_start_ff,
                                    pcol_high_ff, mode_ff, 2'h0};
        ADDR_DISPLAY:    prdata <= {1'b0, iref_int_ff, offset_ff,
                                    mux_ff, start_line_ff, contrast_ff,
                                    scan_down_ff, display_on_ff,
                                    inverse_ff, all_on_ff};
        ADDR_TIMING:     prdata <= {12'h000, com_swap_ff, com_alt_ff,
                                    2'h0, phase2_ff, phase1_ff,
                                    osc_freq_ff, clk_div_ff};
        ADDR_SCROLL:     prdata <= {7'h00, scroll_frames_o, 3'h0,
                                    scroll_left_ff, 1'b0, scroll_end_ff,
                                    1'b0, scroll_code_ff, 1'b0,
                                    scroll_start_ff};
        ADDR_POINTER:    prdata <= {14'h0000, ppage_ff, pcol_low_ff,
                                    ram_page_index_o, 1'b0, col_o};
        ADDR_STATUS:     prdata <= {24'h000000, 3'h0, in_param,
                                    bad_param_ff, ~display_on_ff,
                                    2'h0};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign display_on_o    = display_on_ff;
  assign all_on_o        = all_on_ff;
  assign inverse_o       = inverse_ff;
  assign seg_remap_o     = seg_remap_ff;
  assign scan_down_o     = scan_down_ff;
  assign contrast_o      = contrast_ff;
  assign mux_ratio_o     = mux_ff;
  assign start_line_o    = start_line_ff;
  assign offset_o        = offset_ff;
  // Internal reference only drives while the panel is lit.
  assign iref_internal_o = iref_int_ff && display_on_ff;

endmodule : oled_command_decoder
`default_nettype wire

/* File: host_mcu_model.sv */
// Purpose: Host side model that issues command and data bytes over APB.
// Assumes: One transfer at a time, entered right after a rising edge.
// Notes:   Released address and data show their inverse.
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
  input  wire logic        clk_i,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'hff;
    pwdata = 32'h0;
    pstrb = 4'h1;
  end

  // The bench also hands over refused parameters and a write to the unmapped offset 20h.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // Stale values would hide sampling outside the access.
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge clk_i);
  endtask : xfer
endmodule : host_mcu_model
`default_nettype wire

/* File: cmd_decoder_checker_sva.sv */
// Purpose: Port checker for the display command decoder.
// Assumes: Command bytes arrive as APB writes at ADDR_CMD.
// Notes:   Bound to the decoder; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module cmd_decoder_checker
  import cmd_decoder_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic       pready,
  input  wire logic       pslverr,
  input  wire logic       display_on_o,
  input  wire logic       iref_internal_o,
  input  wire logic [7:0] contrast_o,
  input  wire logic [5:0] mux_ratio_o,
  input  wire logic [5:0] start_line_o,
  input  wire logic [5:0] offset_o,
  input  wire logic [6:0] col_o,
  input  wire logic [8:0] scroll_frames_o
);
  logic any_wr;
  logic cmd_wr;
  assign any_wr = psel && penable && pwrite;
  assign cmd_wr = any_wr && (paddr == ADDR_CMD);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_ready_high: assert property (pready)
    else $error("pready dropped");
  a_no_slverr: assert property (!pslverr)
    else $error("pslverr raised");
  a_iref_gated: assert property (iref_internal_o |-> display_on_o)
    else $error("iref on while display off");
  a_mux_floor: assert property (mux_ratio_o >= MUX_MIN_VALID)
    else $error("mux value below floor");
  a_frames_legal: assert property (scroll_frames_o inside
    {9'h005, 9'h040, 9'h080, 9'h100, 9'h003, 9'h004, 9'h019, 9'h002})
    else $error("interval outside table");
  a_contrast_cause: assert property ($changed(contrast_o) |-> $past(cmd_wr))
    else $error("contrast moved without a command");
  a_display_cause: assert property ($changed(display_on_o) |-> $past(cmd_wr))
    else $error("display moved without a command");
  a_start_cause: assert property ($changed(start_line_o) |-> $past(cmd_wr))
    else $error("start line moved without a command");
  a_offset_cause: assert property ($changed(offset_o) |-> $past(cmd_wr))
    else $error("offset moved without a command");
  a_col_cause: assert property ($changed(col_o) |->
    ($past(any_wr) || $past(any_wr, 2) || $past(any_wr, 3)))
    else $error("column moved without a write");

  c_display_on: cover property ($rose(display_on_o));
  c_iref_on: cover property (iref_internal_o);
  c_col_wrap: cover property ($past(col_o) == 7'h7f && col_o == 7'h00);
  c_slow_scroll: cover property (scroll_frames_o == 9'h100);
endmodule : cmd_decoder_checker

bind oled_command_decoder cmd_decoder_checker u_checker (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .display_on_o(display_on_o), .iref_internal_o(iref_internal_o),
  .contrast_o(contrast_o), .mux_ratio_o(mux_ratio_o),
  .start_line_o(start_line_o), .offset_o(offset_o), .col_o(col_o),
  .scroll_frames_o(scroll_frames_o)
);
`default_nettype wire

/* File: oled_command_decoder_test.sv */
// Purpose: Self-checking bench for the display command decoder.
// Assumes: Zero-wait APB.
// Notes:   Ordinary commands run from a table; the rest by hand.
`timescale 1ns/1ps
`default_nettype none
module oled_command_decoder_test;
  import cmd_decoder_pkg::*;
  typedef struct packed {
    logic [7:0] op; logic [7:0] par; logic np; logic [3:0] sel; logic [8:0] exp;
  } row_s;
  logic        clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr;
  logic        display_on_o, all_on_o, inverse_o, seg_remap_o, scan_down_o;
  logic        iref_internal_o;
  logic [7:0]  paddr, contrast_o;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [5:0]  mux_ratio_o, start_line_o, offset_o;
  logic [6:0]  col_o;
  logic [2:0]  ram_page_index_o;
  logic [8:0]  scroll_frames_o;
  logic [31:0] ov [10];
  logic [8:0]  fr [8] = '{9'h005, 9'h040, 9'h080, 9'h100,
                          9'h003, 9'h004, 9'h019, 9'h002};
  int          fails, total_checks, cycles;
  row_s rows [] = '{
    '{8'haf, 8'h00, 1'b0, 4'h0, 9'h001}, '{8'ha5, 8'h00, 1'b0, 4'h1, 9'h001},
    '{8'ha4, 8'h00, 1'b0, 4'h1, 9'h000}, '{8'ha7, 8'h00, 1'b0, 4'h2, 9'h001},
    '{8'ha6, 8'h00, 1'b0, 4'h2, 9'h000}, '{8'ha1, 8'h00, 1'b0, 4'h3, 9'h001},
    '{8'ha0, 8'h00, 1'b0, 4'h3, 9'h000}, '{8'hc8, 8'h00, 1'b0, 4'h4, 9'h001},
    '{8'hc0, 8'h00, 1'b0, 4'h4, 9'h000}, '{8'h81, 8'h00, 1'b1, 4'h5, 9'h000},
    '{8'h81, 8'haf, 1'b1, 4'h5, 9'h0af}, '{8'he3, 8'h00, 1'b0, 4'h0, 9'h001},
    '{8'h7f, 8'h00, 1'b0, 4'h7, 9'h03f}, '{8'h40, 8'h00, 1'b0, 4'h7, 9'h000},
    '{8'hd3, 8'h3f, 1'b1, 4'h8, 9'h03f}, '{8'ha8, 8'h0f, 1'b1, 4'h6, 9'h00f},
    '{8'ha8, 8'h0e, 1'b1, 4'h6, 9'h00f}, '{8'had, 8'h10, 1'b1, 4'h9, 9'h001},
    '{8'hae, 8'h00, 1'b0, 4'h9, 9'h000}};

  always_comb ov = '{32'(display_on_o), 32'(all_on_o), 32'(inverse_o),
    32'(seg_remap_o), 32'(scan_down_o), 32'(contrast_o), 32'(mux_ratio_o),
    32'(start_line_o), 32'(offset_o), 32'(iref_internal_o)};

  oled_command_decoder DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .display_on_o(display_on_o), .all_on_o(all_on_o), .inverse_o(inverse_o),
    .seg_remap_o(seg_remap_o), .scan_down_o(scan_down_o),
    .contrast_o(contrast_o), .mux_ratio_o(mux_ratio_o),
    .start_line_o(start_line_o), .offset_o(offset_o),
    .iref_internal_o(iref_internal_o), .col_o(col_o),
    .ram_page_index_o(ram_page_index_o), .scroll_frames_o(scroll_frames_o));
  host_mcu_model host (.clk_i(clk_i), .pready(pready), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic summarize;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic cmd(input logic [7:0] b);
    logic [31:0] q;
    host.xfer(1'b1, ADDR_CMD, {24'h0, b}, q);
  endtask : cmd

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h0, q);
    chk("read data", e, q);
  endtask : rdchk

  task automatic settle;
    repeat (3) @(posedge clk_i);
  endtask : settle

  task automatic done(input string n);
    $display("Test %s finished, mismatches %0d", n, fails);
  endtask : done

  // The ceiling only catches a hang.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    logic [31:0] q;
    rst_n_i = 1'b0;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rdchk(ADDR_TIMING, 32'h0004_2280);
    foreach (rows[i]) begin
      cmd(rows[i].op);
      if (rows[i].np) cmd(rows[i].par);
      settle();
      chk("output", 32'(rows[i].exp), ov[rows[i].sel]);
    end
    done("table");
    cmd(8'hd5); cmd(8'ha7); cmd(8'hd9); cmd(8'hf1);
    cmd(8'hd9); cmd(8'h30); cmd(8'hda); cmd(8'h20);
    rdchk(ADDR_TIMING, 32'h0008_31a7);
    done("timing");
    for (int c = 0; c < 8; c++) begin
      // End page 6 never below start page 1.
      cmd({7'h13, c[0]}); cmd(8'h00); cmd(8'h01); cmd({5'h0, c[2:0]});
      cmd(8'h06); cmd(8'h00); cmd(8'hff);
      settle();
      chk("frames", 32'(fr[c]), 32'(scroll_frames_o));
      rdchk(ADDR_SCROLL, {7'h0, fr[c], 3'h0, c[0], 4'h6, 1'b0, c[2:0], 4'h1});
    end
    done("scroll");
    cmd(8'hb3); cmd(8'h0e); cmd(8'h17);
    settle();
    chk("column", 32'h7e, 32'(col_o));
    chk("page", 32'h3, 32'(ram_page_index_o));
    host.xfer(1'b1, ADDR_DATA_ACCESS, 32'h0, q);
    settle();
    chk("column", 32'h7f, 32'(col_o));
    host.xfer(1'b1, ADDR_DATA_ACCESS, 32'h0, q);
    settle();
    chk("column", 32'h00, 32'(col_o));
    chk("page", 32'h3, 32'(ram_page_index_o));
    cmd(8'h20); cmd(8'h00); cmd(8'hb5); cmd(8'h20); cmd(8'h03); cmd(8'hb6);
    settle();
    chk("page", 32'h3, 32'(ram_page_index_o));
    cmd(8'h21); cmd(8'h05); cmd(8'h10); cmd(8'h22); cmd(8'h01); cmd(8'h04);
    rdchk(ADDR_ADDRESSING, 32'h2110_0570);
    cmd(8'h20); cmd(8'h02); cmd(8'hb6);
    settle();
    chk("page", 32'h6, 32'(ram_page_index_o));
    done("pointer");
    host.xfer(1'b1, 8'h20, 32'hff, q);
    rdchk(8'h20, 32'h0);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk("contrast", 32'h7f, 32'(contrast_o));
    chk("display", 32'h0, 32'(display_on_o));
    chk("mux", 32'h3f, 32'(mux_ratio_o));
    chk("column", 32'h0, 32'(col_o));
    chk("frames", 32'h5, 32'(scroll_frames_o));
    rdchk(ADDR_TIMING, 32'h0004_2280);
    done("reset");
    summarize();
  end
endmodule : oled_command_decoder_test
`default_nettype wire
